//--- rtl/idm_top.sv
// internal data memory map: register banks, bit area, stack and register slave
// Functional notes
// - bytes 0x00-0x1f are four eight-register banks
// - only the active bank serves register references
// - status bits 4 and 3 give bank number
// - indirect pointer from register zero or one
// - bytes 0x20-0x2f also bit addressable
// - bit address = byte offset times eight plus bit
// - bit versus byte chosen by operation type
// - stack may use all 256 bytes
// - push writes pointer plus one, then increments
// - stack pointer resets to 0x07
`timescale 1ns/1ns
module idm_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire idm_pkg::idm_req_t coreReq,
  output idm_pkg::idm_rsp_t coreRsp,
  output logic [7:0] stackTop,
  output logic [1:0] activeBank,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import idm_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [7:0] stackTop_reg;
  logic [7:0] stackTop_next;
  logic [7:0] statusWord_reg;
  logic [7:0] memAddr_reg;
  idm_rsp_t rsp_reg;
  logic [7:0] ramRdAddr;
  logic [7:0] ramRdData;
  logic ramWrEn;
  logic [7:0] ramWrAddr;
  logic [7:0] ramWrData;
  logic [7:0] ramWrMask;
  logic [7:0] coreAddr;
  logic [7:0] coreRdData;
  logic [7:0] ptrByte;
  logic [2:0] bitIdx;
  logic bitInRange;
  logic busWr;
  logic [11:0] busWrAddr;
  logic [7:0] busWrByte;
  logic busWrOk;
  logic [11:0] busRdAddr;
  logic [7:0] busRdByte;
  logic busRdOk;
  logic coreUsesRam;
  logic busMemWr;

  assign stackTop = stackTop_reg;
  assign activeBank = idm_bank(statusWord_reg);
  assign coreRsp = rsp_reg;

  // ****************************************
  // core address formation
  // ****************************************
  // pointer register value from the active bank, read through the first array's port (uRam)
  assign ptrByte = ramRdData;
  assign bitIdx = coreReq.addr[BIT_IDX_W-1:0];
  assign bitInRange = !coreReq.addr[7];

  always_comb begin
    coreAddr = coreReq.addr;
    unique case (coreReq.op)
      OP_WREG: coreAddr = idm_wreg_addr(statusWord_reg, coreReq.addr[REGS_PER_BANK_LOG-1:0]);
      OP_BIT: coreAddr = BIT_BASE + {4'h0, coreReq.addr[6:3]};
      OP_PUSH: coreAddr = stackTop_reg + ONE_BYTE;
      OP_POP: coreAddr = stackTop_reg;
      default: coreAddr = coreReq.addr;
    endcase
  end

  // indirect ops need the pointer first; it is read combinationally via the pointer array's port, not the data port
  // pointer from register zero or one
  logic [7:0] ptrRegAddr;
  assign ptrRegAddr = idm_wreg_addr(statusWord_reg, {2'h0, coreReq.addr[0]});

  // ram port arbitration: indirect uses a two-step lookup inside one cycle
  logic [7:0] indTarget;
  logic [7:0] ramRdAddr2;
  logic [7:0] ramRdData2;
  assign indTarget = ramRdData;
  assign ramRdAddr = (coreReq.op == OP_INDIRECT) ? ptrRegAddr : coreAddr;
  assign ramRdAddr2 = (coreReq.valid && coreReq.op != OP_SFR) ? ((coreReq.op == OP_INDIRECT) ? indTarget : coreAddr)
                                                               : memAddr_reg;

  // bank region held in one array
  // full 256-byte stack reach
  // pointer copy takes every write too, or indirect ops would read stale pointers
  idm_ram uRam (
    .ref_clk(ref_clk),
    .rdAddr(ramRdAddr),
    .rdData(ramRdData),
    .wrEn(ramWrEn),
    .wrAddr(ramWrAddr),
    .wrData(ramWrData),
    .wrMask(ramWrMask)
  );

  idm_ram uRamData (
    .ref_clk(ref_clk),
    .rdAddr(ramRdAddr2),
    .rdData(ramRdData2),
    .wrEn(ramWrEn),
    .wrAddr(ramWrAddr),
    .wrData(ramWrData),
    .wrMask(ramWrMask)
  );

  // pointer copy array kept in step with data array
  assign coreUsesRam = coreReq.valid && coreReq.op != OP_SFR;

  // ****************************************
  // write path
  // ****************************************
  assign busMemWr = busWr && busWrAddr == REG_MEM_DATA;

  always_comb begin
    ramWrEn = 1'b0;
    ramWrAddr = ramRdAddr2;
    ramWrData = coreReq.wdata;
    ramWrMask = 8'hff;
    if (coreUsesRam) begin
      unique case (coreReq.op)
        OP_BIT: begin
          ramWrEn = coreReq.write && bitInRange;
          ramWrMask = 8'h01 << bitIdx;
          ramWrData = {8{coreReq.wdata[0]}};
        end
        OP_PUSH: ramWrEn = 1'b1;
        OP_POP: ramWrEn = 1'b0;
        default: ramWrEn = coreReq.write;
      endcase
    end else if (busMemWr) begin
      ramWrEn = 1'b1;
      ramWrAddr = memAddr_reg;
      ramWrData = busWrByte;
    end
  end

  // mirror writes into the pointer array so both copies agree
  // second array instance written identically
  // ****************************************
  // read data to core
  // ****************************************
  always_comb begin
    coreRdData = ramRdData2;
    unique case (coreReq.op)
      OP_BIT: coreRdData = {7'h00, ramRdData2[bitIdx] & bitInRange};
      OP_SFR: coreRdData = (coreReq.addr == SFR_STACK_TOP) ? stackTop_reg : 8'h00;
      default: coreRdData = ramRdData2;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= '{valid: coreReq.valid, rdata: coreRdData};
    end
  end

  // ****************************************
  // stack pointer
  // ****************************************
  always_comb begin
    stackTop_next = stackTop_reg;
    if (coreReq.valid && coreReq.op == OP_PUSH) begin
      stackTop_next = stackTop_reg + ONE_BYTE;
    end else if (coreReq.valid && coreReq.op == OP_POP) begin
      stackTop_next = stackTop_reg - ONE_BYTE;
    end else if (coreReq.valid && coreReq.op == OP_SFR && coreReq.write && coreReq.addr == SFR_STACK_TOP) begin
      stackTop_next = coreReq.wdata;
    end else if (busWr && busWrAddr == REG_STACK_TOP) begin
      stackTop_next = busWrByte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stackTop_reg <= STACK_RESET;
    end else begin
      stackTop_reg <= stackTop_next;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      statusWord_reg <= 8'h00;
      memAddr_reg <= 8'h00;
    end else if (busWr) begin
      if (busWrAddr == REG_STATUS_WORD) begin
        statusWord_reg <= busWrByte;
      end
      if (busWrAddr == REG_MEM_ADDR) begin
        memAddr_reg <= busWrByte;
      end
    end
  end

  assign busWrOk = busWrAddr == REG_STACK_TOP || busWrAddr == REG_STATUS_WORD || busWrAddr == REG_MEM_ADDR
                   || busWrAddr == REG_MEM_DATA;

  always_comb begin
    busRdOk = 1'b1;
    unique case (busRdAddr)
      REG_STACK_TOP: busRdByte = stackTop_reg;
      REG_STATUS_WORD: busRdByte = statusWord_reg;
      REG_MEM_ADDR: busRdByte = memAddr_reg;
      REG_MEM_DATA: busRdByte = coreUsesRam ? 8'h00 : ramRdData2;
      default: begin
        busRdByte = 8'h00;
        busRdOk = 1'b0;
      end
    endcase
  end

  idm_axil uBus (
    .ref_clk(ref_clk),
    .rst(rst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wrStrobe(busWr),
    .wrAddr(busWrAddr),
    .wrByte(busWrByte),
    .wrOk(busWrOk),
    .rdStrobe(),
    .rdAddr(busRdAddr),
    .rdByte(busRdByte),
    .rdOk(busRdOk)
  );

  // ****************************************
  // checks
  // ****************************************
  a_stack_reset: assert property (@(posedge ref_clk) $fell(rst) |-> stackTop_reg == STACK_RESET)
    else $error("stack pointer not at reset value");
  a_push_incr: assert property (@(posedge ref_clk) disable iff (rst)
    coreReq.valid && coreReq.op == OP_PUSH |=> stackTop_reg == $past(stackTop_reg) + ONE_BYTE)
    else $error("push did not increment pointer");
  a_pop_decr: assert property (@(posedge ref_clk) disable iff (rst)
    coreReq.valid && coreReq.op == OP_POP |=> stackTop_reg == $past(stackTop_reg) - ONE_BYTE)
    else $error("pop did not decrement pointer");
  a_push_target: assert property (@(posedge ref_clk) disable iff (rst)
    coreReq.valid && coreReq.op == OP_PUSH |-> ramWrEn && ramWrAddr == stackTop_reg + ONE_BYTE)
    else $error("push wrote wrong address");
  a_bank_wreg: assert property (@(posedge ref_clk) disable iff (rst)
    coreReq.valid && coreReq.op == OP_WREG |-> coreAddr[7:5] == 3'h0 && coreAddr[4:3] == activeBank)
    else $error("register outside active bank");
  a_bit_byte: assert property (@(posedge ref_clk) disable iff (rst)
    coreReq.valid && coreReq.op == OP_BIT |-> coreAddr >= BIT_BASE && coreAddr <= BIT_LAST)
    else $error("bit address outside bit area");
  a_bit_mask: assert property (@(posedge ref_clk) disable iff (rst)
    coreReq.valid && coreReq.op == OP_BIT && ramWrEn |-> $onehot(ramWrMask))
    else $error("bit write touched more than one bit");
  a_sfr_read: assert property (@(posedge ref_clk) disable iff (rst)
    coreReq.valid && coreReq.op == OP_SFR && coreReq.addr == SFR_STACK_TOP |=> coreRsp.rdata == $past(stackTop_reg))
    else $error("stack pointer read mismatch");
endmodule : idm_top

//--- rtl/idm_pkg.sv
// constants, types and bus carriers shared by the internal data memory map
package idm_pkg;
  // ****************************************
  // memory geometry
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam logic [7:0] BANK_BASE = 8'h00;
  localparam logic [7:0] BANK_LAST = 8'h1f;
  localparam logic [7:0] BIT_BASE = 8'h20;
  localparam logic [7:0] BIT_LAST = 8'h2f;
  localparam logic [6:0] BIT_ADDR_LAST = 7'h7f;
  localparam int BANK_SEL_LO_POS = 3;
  localparam int BANK_SEL_HI_POS = 4;
  localparam int REGS_PER_BANK_LOG = 3;
  localparam int BIT_IDX_W = 3;
  localparam logic [7:0] STACK_RESET = 8'h07;
  localparam logic [7:0] SFR_STACK_TOP = 8'h81;
  localparam logic [7:0] ONE_BYTE = 8'h01;

  // ****************************************
  // axi4-lite register map
  // ****************************************
  localparam logic [11:0] REG_STACK_TOP = 12'h081 << 2;
  localparam logic [11:0] REG_STATUS_WORD = 12'h100;
  localparam logic [11:0] REG_MEM_ADDR = 12'h104;
  localparam logic [11:0] REG_MEM_DATA = 12'h108;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // core side operations
  // ****************************************
  typedef enum logic [3:0] {
    OP_BYTE = 4'h0,
    OP_BIT = 4'h1,
    OP_WREG = 4'h2,
    OP_INDIRECT = 4'h3,
    OP_PUSH = 4'h4,
    OP_POP = 4'h5,
    OP_SFR = 4'h6
  } idm_op_t;

  typedef struct packed {
    logic valid;
    idm_op_t op;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } idm_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } idm_rsp_t;

  typedef struct packed {
    logic [11:0] addr;
    logic valid;
  } idm_ax_t;

  // bank number from status word
  function automatic logic [1:0] idm_bank(input logic [7:0] program_status_word);
    return {program_status_word[BANK_SEL_HI_POS], program_status_word[BANK_SEL_LO_POS]};
  endfunction : idm_bank

  // byte address of a working register in the active bank
  function automatic logic [7:0] idm_wreg_addr(input logic [7:0] program_status_word, input logic [2:0] idx);
    return {3'h0, idm_bank(program_status_word), idx};
  endfunction : idm_wreg_addr
endpackage : idm_pkg

//--- rtl/idm_ram.sv
// 256-byte internal data memory array with bit-granular write
`timescale 1ns/1ns
module idm_ram (
  input wire logic ref_clk,
  input wire logic [7:0] rdAddr,
  output logic [7:0] rdData,
  input wire logic wrEn,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] wrMask
);
  import idm_pkg::*;
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // read is asynchronous so the response register captures data in the request cycle
  assign rdData = mem[rdAddr];

  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= (mem[wrAddr] & ~wrMask) | (wrData & wrMask);
    end
  end
endmodule : idm_ram

//--- rtl/idm_axil.sv
// axi4-lite slave front end, one write and one read at a time
`timescale 1ns/1ns
module idm_axil (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wrStrobe,
  output logic [11:0] wrAddr,
  output logic [7:0] wrByte,
  input wire logic wrOk,
  output logic rdStrobe,
  output logic [11:0] rdAddr,
  input wire logic [7:0] rdByte,
  input wire logic rdOk
);
  import idm_pkg::*;
  idm_ax_t aw_reg;
  logic wHave_reg;
  logic [7:0] wByte_reg;
  logic wLane_reg;

  assign awready = !aw_reg.valid && !bvalid;
  assign wready = !wHave_reg && !bvalid;
  assign arready = !rvalid;
  assign wrStrobe = aw_reg.valid && wHave_reg && !bvalid;
  assign wrAddr = aw_reg.addr;
  // only byte lane zero carries data; without it a zero byte is written
  assign wrByte = wLane_reg ? wByte_reg : 8'h00;
  assign rdStrobe = arvalid && arready;
  assign rdAddr = araddr;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_reg <= '0;
      wHave_reg <= 1'b0;
      wByte_reg <= 8'h00;
      wLane_reg <= 1'b0;
    end else if (wrStrobe) begin
      aw_reg <= '0;
      wHave_reg <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_reg <= '{addr: awaddr, valid: 1'b1};
      end
      if (wvalid && wready) begin
        wHave_reg <= 1'b1;
        wByte_reg <= wdata[7:0];
        wLane_reg <= wstrb[0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wrStrobe) begin
      bvalid <= 1'b1;
      bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (rdStrobe) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rdOk ? rdByte : 8'h00};
      rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : idm_axil

//--- verification/idm_core_model.sv
// behavioural model of the core execution logic that issues data memory requests
`timescale 1ns/1ns
module idm_core_model
  import idm_pkg::*;
(
  input wire logic ref_clk,
  output idm_pkg::idm_req_t coreReq,
  input wire idm_pkg::idm_rsp_t coreRsp
);
  initial begin
    coreReq = '0;
  end

  // ****************************************
  // one request, answer sampled a cycle later
  // ****************************************
  task automatic issue(input idm_op_t op, input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] rd, output logic ok);
    @(posedge ref_clk);
    coreReq <= '{valid: 1'b1, op: op, write: wr, addr: a, wdata: d};
    @(posedge ref_clk);
    // released operands must not keep the old value, or stale use goes unseen
    coreReq <= '{valid: 1'b0, op: op, write: ~wr, addr: ~a, wdata: ~d};
    #1;
    ok = coreRsp.valid;
    rd = coreRsp.rdata;
  endtask : issue
endmodule : idm_core_model

//--- verification/test_internal_data_memory_map.sv
// self-checking bench for the internal data memory map
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module test_internal_data_memory_map;
  import idm_pkg::*;
  logic ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, activeBank;
  logic [7:0] stackTop;
  idm_req_t coreReq;
  idm_rsp_t coreRsp;
  int n_fail, n_compared, cycles;

  idm_top idm_top_i (.ref_clk(ref_clk), .rst(rst), .coreReq(coreReq), .coreRsp(coreRsp), .stackTop(stackTop),
    .activeBank(activeBank), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  idm_core_model idm_core_model_i (.ref_clk(ref_clk), .coreReq(coreReq), .coreRsp(coreRsp));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ****************************************
  // bus and core access
  // ****************************************
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aT, wT, bT;
    bT = 1'b0;
    @(posedge ref_clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    while (!bT) begin
      @(negedge ref_clk);
      aT = awvalid && awready;
      wT = wvalid && wready;
      bT = bvalid && bready;
      r = bresp;
      @(posedge ref_clk);
      if (aT) awvalid <= 1'b0;
      if (wT) wvalid <= 1'b0;
      if (bT) bready <= 1'b0;
    end
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic aT, rT;
    rT = 1'b0;
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!rT) begin
      @(negedge ref_clk);
      aT = arvalid && arready;
      rT = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge ref_clk);
      if (aT) arvalid <= 1'b0;
      if (rT) rready <= 1'b0;
    end
  endtask : axi_read

  task automatic core(input idm_op_t op, input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] rd);
    logic ok;
    idm_core_model_i.issue(op, wr, a, d, rd, ok);
    `CHECK("core answer valid", 1'b1, ok)
  endtask : core

  // ****************************************
  // scenarios
  // ****************************************
  task automatic check_reset;
    logic [31:0] d;
    logic [1:0] r;
    `CHECK("stack pointer after reset", 8'h07, stackTop)
    axi_read(REG_STACK_TOP, d, r);
    `CHECK("stack register reset read", 32'h7, d)
    `CHECK("stack register resp", RESP_OKAY, r)
    `CHECK("bank after reset", 2'h0, activeBank)
  endtask : check_reset

  task automatic check_stack;
    logic [7:0] rd;
    core(OP_PUSH, 1'b1, 8'h00, 8'h11, rd);
    `CHECK("pointer after push", 8'h08, stackTop)
    core(OP_PUSH, 1'b1, 8'h00, 8'h22, rd);
    core(OP_BYTE, 1'b0, 8'h08, 8'h00, rd);
    `CHECK("first push slot", 8'h11, rd)
    core(OP_POP, 1'b0, 8'h00, 8'h00, rd);
    `CHECK("pop data", 8'h22, rd)
    `CHECK("pointer after pop", 8'h08, stackTop)
    // software moves the stack off the register banks
    core(OP_SFR, 1'b1, SFR_STACK_TOP, 8'hfe, rd);
    core(OP_SFR, 1'b0, SFR_STACK_TOP, 8'h00, rd);
    `CHECK("pointer sfr read", 8'hfe, rd)
    core(OP_PUSH, 1'b1, 8'h00, 8'h5a, rd);
    core(OP_PUSH, 1'b1, 8'h00, 8'h6b, rd);
    `CHECK("pointer wraps up", 8'h00, stackTop)
    core(OP_POP, 1'b0, 8'h00, 8'h00, rd);
    `CHECK("pop at byte zero", 8'h6b, rd)
    `CHECK("pointer wraps down", 8'hff, stackTop)
    core(OP_POP, 1'b0, 8'h00, 8'h00, rd);
    `CHECK("pop at top byte", 8'h5a, rd)
  endtask : check_stack

  task automatic check_banks;
    logic [7:0] rd;
    logic [1:0] r;
    for (int b = 0; b < 4; b++) begin
      logic [7:0] bb;
      bb = 8'(b);
      axi_write(REG_STATUS_WORD, {24'h0, 3'h0, bb[1:0], 3'h0}, r);
      `CHECK("active bank", bb[1:0], activeBank)
      core(OP_WREG, 1'b1, 8'h00, 8'h30 + bb, rd);
      core(OP_WREG, 1'b1, 8'h01, 8'h38 + bb, rd);
      core(OP_WREG, 1'b1, 8'h07, 8'hc0 + bb, rd);
      core(OP_BYTE, 1'b0, {bb[4:0], 3'h7}, 8'h00, rd);
      `CHECK("bank register seven", 8'hc0 + bb, rd)
      core(OP_INDIRECT, 1'b1, 8'h01, 8'ha0 + bb, rd);
      core(OP_BYTE, 1'b0, 8'h38 + bb, 8'h00, rd);
      `CHECK("indirect via reg one", 8'ha0 + bb, rd)
      core(OP_INDIRECT, 1'b1, 8'h00, 8'hb0 + bb, rd);
      core(OP_BYTE, 1'b0, 8'h30 + bb, 8'h00, rd);
      `CHECK("indirect via reg zero", 8'hb0 + bb, rd)
    end
    core(OP_WREG, 1'b0, 8'h07, 8'h00, rd);
    `CHECK("only bank three served", 8'hc3, rd)
    core(OP_BYTE, 1'b0, 8'h07, 8'h00, rd);
    `CHECK("bank zero untouched", 8'hc0, rd)
    axi_write(REG_STATUS_WORD, 32'he7, r);
    `CHECK("other status bits ignored", 2'h0, activeBank)
  endtask : check_banks

  task automatic check_bits;
    logic [7:0] rd;
    core(OP_BYTE, 1'b1, 8'h22, 8'h00, rd);
    core(OP_BYTE, 1'b1, 8'h13, 8'h00, rd);
    core(OP_BYTE, 1'b1, 8'h20, 8'h00, rd);
    core(OP_BYTE, 1'b1, 8'h2f, 8'h00, rd);
    core(OP_BIT, 1'b1, 8'h13, 8'h01, rd);
    core(OP_BYTE, 1'b0, 8'h22, 8'h00, rd);
    `CHECK("bit 0x13 in byte 0x22", 8'h08, rd)
    core(OP_BIT, 1'b0, 8'h13, 8'h00, rd);
    `CHECK("bit read back", 8'h01, rd)
    core(OP_BYTE, 1'b0, 8'h13, 8'h00, rd);
    `CHECK("byte at same address", 8'h00, rd)
    core(OP_BIT, 1'b1, 8'h7f, 8'h01, rd);
    core(OP_BIT, 1'b1, 8'h00, 8'h01, rd);
    core(OP_BYTE, 1'b0, 8'h2f, 8'h00, rd);
    `CHECK("last bit address", 8'h80, rd)
    core(OP_BYTE, 1'b0, 8'h20, 8'h00, rd);
    `CHECK("first bit address", 8'h01, rd)
    core(OP_BIT, 1'b1, 8'h13, 8'h00, rd);
    core(OP_BYTE, 1'b0, 8'h22, 8'h00, rd);
    `CHECK("bit cleared", 8'h00, rd)
    core(OP_BIT, 1'b0, 8'h80, 8'h00, rd);
    `CHECK("bit beyond area", 8'h00, rd)
  endtask : check_bits

  task automatic check_bus;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] rd;
    axi_write(REG_STACK_TOP, 32'h5a, r);
    `CHECK("stack write pointer", 8'h5a, stackTop)
    axi_read(REG_STACK_TOP, d, r);
    `CHECK("stack register read", 32'h5a, d)
    axi_write(12'h300, 32'h1, r);
    `CHECK("unmapped write resp", RESP_SLVERR, r)
    axi_read(12'h300, d, r);
    `CHECK("unmapped read resp", RESP_SLVERR, r)
    `CHECK("unmapped read data", 32'h0, d)
    axi_write(REG_MEM_ADDR, 32'h40, r);
    axi_write(REG_MEM_DATA, 32'h77, r);
    core(OP_BYTE, 1'b0, 8'h40, 8'h00, rd);
    `CHECK("upper memory byte", 8'h77, rd)
    axi_read(REG_MEM_DATA, d, r);
    `CHECK("memory window read", 32'h77, d)
  endtask : check_bus

  // ****************************************
  // verdict and run control
  // ****************************************
  task automatic end_sim;
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    n_fail = 0; n_compared = 0; cycles = 0;
    rst = 1'b1; awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0; wvalid = 1'b0; bready = 1'b0;
    araddr = '0; arvalid = 1'b0; rready = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    check_reset();
    check_stack();
    check_banks();
    check_bits();
    check_bus();
    end_sim();
  end
endmodule : test_internal_data_memory_map
